// ==== hdl/apbo_port_clock.sv ====
`timescale 1ns/1ps
`include "apbo_map.svh"
// Bit-clock generator and frame-sync slot positioning for the serial port
module apbo_port_clock #(
   parameter int WORD_W = 32
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic conv_clk_tick,
   input wire logic modulator_clock_tick,
   input wire logic [1:0] iface_format,
   input wire logic bitclk_dir_out,
   input wire logic core_powered,
   input wire logic ext_bitclk,
   input wire logic wordclk_in,
   output logic bitclk_out,
   output logic bitclk_oe_n,
   output logic bitclk_sec_out,
   output logic clocks_active,
   output logic slot_start,
   input wire logic word_valid,
   output logic word_ready,
   input wire logic [WORD_W-1:0] word_data,
   output logic serial_out
);
   // Register file
   logic [7:0] data_slot_offset;
   logic [7:0] port_clock_control;
   logic [7:0] bit_clock_divider;
   // Divider state
   logic [7:0] div_count;
   logic bitclk_int;
   logic bitclk_int_q;
   logic div_running;
   logic bitclk_divider_input;
   logic [7:0] bitclk_divide_ratio;
   // Bit-clock selected for the port
   logic port_bitclk;
   logic port_bitclk_q;
   logic bit_edge;
   logic wordclk_q;
   // Slot sequencer
   apbo_pkg::apbo_slot_state_t state;
   logic [7:0] slot_count;
   logic [$clog2(WORD_W+1)-1:0] bit_idx;
   logic [WORD_W-1:0] shift_reg;
   logic buf_valid;
   logic [WORD_W-1:0] buf_data;
   logic buf_take;

   // Elaboration check: the shifter needs at least two bits for its tail slice
   if (WORD_W < 2 || WORD_W > 255) begin : g_word_w_check
      $error("apbo_port_clock: WORD_W out of range");
   end

   // Ratio decode: zero code means the largest ratio
   function automatic logic [7:0] ratio_of(input logic [6:0] code);
      ratio_of = (code == 7'h00) ? 8'h80 : {1'b0, code};
   endfunction : ratio_of

   // Register writes; divider resets to ratio one, powered down
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         data_slot_offset <= `APBO_RST_SLOT_OFFSET;
         port_clock_control <= `APBO_RST_CLOCK_CTRL;
         bit_clock_divider <= `APBO_RST_BITCLK_DIV;
      end else if (clk_en && reg_wr) begin
         case (reg_addr)
            `APBO_ADDR_SLOT_OFFSET: data_slot_offset <= reg_wdata;
            // Upper nibble is reserved and kept at zero
            `APBO_ADDR_CLOCK_CTRL: port_clock_control <= {4'h0, reg_wdata[3:0]};
            `APBO_ADDR_BITCLK_DIV: bit_clock_divider <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Read data from a register
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         case (reg_addr)
            `APBO_ADDR_SLOT_OFFSET: reg_rdata <= data_slot_offset;
            `APBO_ADDR_CLOCK_CTRL: reg_rdata <= port_clock_control;
            `APBO_ADDR_BITCLK_DIV: reg_rdata <= bit_clock_divider;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   // (RULE4) source field picks tick
   always_comb begin
      case (port_clock_control[`APBO_CTRL_SRC_LSB +: 2])
         `APBO_SRC_CONVERTER: bitclk_divider_input = conv_clk_tick;
         `APBO_SRC_MODULATOR: bitclk_divider_input = modulator_clock_tick;
         // Reserved codes give no input, so the divider stalls
         default: bitclk_divider_input = 1'b0;
      endcase
   end

   // (RULE6) ratio from field
   assign bitclk_divide_ratio = ratio_of(bit_clock_divider[6:0]);
   // (RULE5) power bit gates divider
   // (RULE3) keep-alive overrides core power-down
   assign div_running = bit_clock_divider[`APBO_DIV_POWER_BIT]
      && (core_powered || port_clock_control[`APBO_CTRL_KEEP_BIT]);
   assign clocks_active = div_running;

   // (RULE9) one bit-clock period per N input ticks, two ticks when N is one
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         div_count <= 8'h00;
         bitclk_int <= 1'b0;
      end else if (clk_en) begin
         if (!div_running) begin
            div_count <= 8'h00;
            bitclk_int <= 1'b0;
         end else if (bitclk_divider_input) begin
            // High for the first half, low for the rest; ratio one toggles each tick
            if (div_count + 8'h01 >= bitclk_divide_ratio) begin
               div_count <= 8'h00;
               bitclk_int <= (bitclk_divide_ratio == 8'h01) ? ~bitclk_int : 1'b1;
            end else begin
               div_count <= div_count + 8'h01;
               if (bitclk_divide_ratio != 8'h01 && div_count + 8'h01 == (bitclk_divide_ratio >> 1))
                  bitclk_int <= 1'b0;
            end
         end
      end
   end

   // (RULE8) drive only when direction is output
   // (RULE2) inversion on both bit clocks
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         bitclk_out <= 1'b0;
         bitclk_sec_out <= 1'b0;
      end else if (clk_en) begin
         bitclk_out <= bitclk_int ^ port_clock_control[`APBO_CTRL_INVERT_BIT];
         bitclk_sec_out <= bitclk_int ^ port_clock_control[`APBO_CTRL_INVERT_BIT];
      end
   end
   // Enable is low while driving
   assign bitclk_oe_n = ~(bitclk_dir_out && div_running);

   // Bit clock used internally, with polarity applied to either source
   assign port_bitclk = (bitclk_dir_out ? bitclk_int : ext_bitclk)
      ^ port_clock_control[`APBO_CTRL_INVERT_BIT];
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         port_bitclk_q <= 1'b0;
         wordclk_q <= 1'b0;
      end else if (clk_en) begin
         port_bitclk_q <= port_bitclk;
         wordclk_q <= wordclk_in;
      end
   end
   assign bit_edge = port_bitclk && !port_bitclk_q;

   // Words wait here so a late slot never drops one
   apbo_word_buffer #(
      .WIDTH(WORD_W)
   ) apbo_word_buffer_inst (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .in_valid(word_valid),
      .in_ready(word_ready),
      .in_data(word_data),
      .out_valid(buf_valid),
      .out_ready(buf_take),
      .out_data(buf_data)
   );
   assign buf_take = (state == apbo_pkg::APBO_SLOT) && (bit_idx == '0) && bit_edge;

   // (RULE7) slot timing only in frame-sync format
   // (RULE1) count offset bit clocks after rise
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state <= apbo_pkg::APBO_IDLE;
         slot_count <= 8'h00;
         bit_idx <= '0;
         shift_reg <= '0;
         serial_out <= 1'b0;
         slot_start <= 1'b0;
      end else if (clk_en) begin
         slot_start <= 1'b0;
         case (state)
            apbo_pkg::APBO_IDLE: begin
               // Word-clock rise opens a frame
               if (iface_format == `APBO_FMT_DSP && wordclk_in && !wordclk_q) begin
                  slot_count <= 8'h00;
                  bit_idx <= '0;
                  state <= (data_slot_offset == 8'h00) ? apbo_pkg::APBO_SLOT
                                                     : apbo_pkg::APBO_WAIT;
                  slot_start <= (data_slot_offset == 8'h00);
               end
            end
            apbo_pkg::APBO_WAIT: begin
               if (bit_edge) begin
                  if (slot_count + 8'h01 == data_slot_offset) begin
                     state <= apbo_pkg::APBO_SLOT;
                     slot_start <= 1'b1;
                  end
                  slot_count <= slot_count + 8'h01;
               end
            end
            apbo_pkg::APBO_SLOT: begin
               if (bit_edge) begin
                  // A missing word shifts zeros rather than stale data
                  if (bit_idx == '0) begin
                     shift_reg <= buf_valid ? {buf_data[WORD_W-2:0], 1'b0} : '0;
                     serial_out <= buf_valid ? buf_data[WORD_W-1] : 1'b0;
                  end else begin
                     shift_reg <= {shift_reg[WORD_W-2:0], 1'b0};
                     serial_out <= shift_reg[WORD_W-1];
                  end
                  if (bit_idx == ($clog2(WORD_W+1))'(WORD_W - 1)) begin
                     state <= apbo_pkg::APBO_IDLE;
                  end
                  bit_idx <= bit_idx + 1'b1;
               end
            end
            default: state <= apbo_pkg::APBO_IDLE;
         endcase
      end
   end
endmodule : apbo_port_clock

// ==== include/apbo_map.svh ====
// Functional notes
// (RULE1) DSP slot starts 0..255 bit clocks after rise
// (RULE2) Inversion bit flips primary and secondary bit clock
// (RULE3) Keep-alive bit runs clocks with converter down
// (RULE4) Source 00 converter clock, 01 modulator clock
// (RULE5) Divider runs only with power bit set
// (RULE6) Ratio equals field; zero means 128
// (RULE7) Format field 01 selects frame-sync mode
// (RULE8) Direction bit 1: device drives bit clock
// (RULE9) Output frequency is input divided by N; at ratio one the code divides by two
`ifndef APBO_MAP_SVH
`define APBO_MAP_SVH
`define APBO_ADDR_SLOT_OFFSET 8'h1c
`define APBO_ADDR_CLOCK_CTRL 8'h1d
`define APBO_ADDR_BITCLK_DIV 8'h1e
`define APBO_RST_SLOT_OFFSET 8'h00
`define APBO_RST_CLOCK_CTRL 8'h00
`define APBO_RST_BITCLK_DIV 8'h01
`define APBO_CTRL_INVERT_BIT 3
`define APBO_CTRL_KEEP_BIT 2
`define APBO_CTRL_SRC_LSB 0
`define APBO_DIV_POWER_BIT 7
`define APBO_FMT_DSP 2'h1
`define APBO_SRC_CONVERTER 2'h0
`define APBO_SRC_MODULATOR 2'h1
`define APBO_BUF_DEPTH 2
`endif

// ==== include/apbo_pkg.sv ====
package apbo_pkg;
   // Divider input choice
   typedef enum logic [1:0] {
      APBO_SRC_CONV,
      APBO_SRC_MOD,
      APBO_SRC_RSVD
   } apbo_src_t;
   // Slot-offset sequencer state
   typedef enum logic [1:0] {
      APBO_IDLE,
      APBO_WAIT,
      APBO_SLOT
   } apbo_slot_state_t;
endpackage : apbo_pkg

// ==== hdl/apbo_word_buffer.sv ====
`timescale 1ns/1ps
`include "apbo_map.svh"
// Two-entry buffer with read data taken straight from storage
module apbo_word_buffer #(
   parameter int WIDTH = 32
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   // Storage of two words
   logic [WIDTH-1:0] mem [0:1];
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] count;
   logic do_wr;
   logic do_rd;
   // Elaboration check: a zero-width word cannot be stored
   if (WIDTH < 1) begin : g_width_check
      $error("apbo_word_buffer: WIDTH must be positive");
   end
   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign do_wr = clk_en && in_valid && in_ready;
   assign do_rd = clk_en && out_valid && out_ready;
   // Head word read straight from storage; two words do not warrant a read register
   assign out_data = mem[rd_ptr];
   // Write side
   always_ff @(posedge ref_clk) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data;
      end
   end
   // Pointers and occupancy
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         if (do_wr) wr_ptr <= ~wr_ptr;
         if (do_rd) rd_ptr <= ~rd_ptr;
         count <= count + {1'b0, do_wr} - {1'b0, do_rd};
      end
   end
endmodule : apbo_word_buffer

// ==== sim/apbo_port_clock_asserts.sv ====
`timescale 1ns/1ps
`include "apbo_map.svh"
// Checker on the port clock outputs, judged against shadowed register writes
module apbo_port_clock_asserts (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [1:0] iface_format,
   input wire logic bitclk_dir_out,
   input wire logic core_powered,
   input wire logic bitclk_out,
   input wire logic bitclk_oe_n,
   input wire logic bitclk_sec_out,
   input wire logic clocks_active,
   input wire logic slot_start
);
   logic [7:0] sh_ctrl; // Expected control value, upper nibble reads zero
   logic [7:0] sh_div; // Expected divider value
   // Shadow registers follow the write strobe exactly as the block should
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sh_ctrl <= `APBO_RST_CLOCK_CTRL;
         sh_div <= `APBO_RST_BITCLK_DIV;
      end else if (clk_en && reg_wr && reg_addr == `APBO_ADDR_CLOCK_CTRL) begin
         sh_ctrl <= reg_wdata & 8'h0f;
      end else if (clk_en && reg_wr && reg_addr == `APBO_ADDR_BITCLK_DIV) begin
         sh_div <= reg_wdata;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   a_active_level: assert property (
      clocks_active == (sh_div[7] && (core_powered || sh_ctrl[2])))
      else $error("clocks_active disagrees with power and keep-alive");
   a_oe_release: assert property (!bitclk_dir_out |-> bitclk_oe_n)
      else $error("bit clock driven while direction is input");
   a_sec_same: assert property (bitclk_sec_out == bitclk_out)
      else $error("secondary bit clock polarity differs");
   // Power-off reaches the pin through two flops, so four quiet cycles are needed
   a_pwr_still: assert property (
      (!sh_div[7] && $stable(sh_ctrl))[*4] |-> $stable(bitclk_out))
      else $error("bit clock moves with divider powered down");
   a_idle_level: assert property (
      (!clocks_active && clk_en && $stable(sh_ctrl))[*4] |-> bitclk_out == sh_ctrl[3])
      else $error("stopped bit clock does not rest at the inversion level");
   a_oe_drive: assert property (bitclk_dir_out && clocks_active |-> !bitclk_oe_n)
      else $error("bit clock not driven while direction is output");
   a_rsvd_still: assert property (
      (sh_ctrl[1] && $stable(sh_ctrl))[*3] |-> $stable(bitclk_out))
      else $error("bit clock moves with reserved source");
   a_slot_single: assert property (slot_start |=> !slot_start)
      else $error("slot start longer than one cycle");
   a_slot_fmt: assert property (
      slot_start |-> $past(iface_format) == `APBO_FMT_DSP)
      else $error("slot start outside frame-sync format");
   a_div_read: assert property (
      !$past(sys_rst) && $past(reg_addr) == `APBO_ADDR_BITCLK_DIV
      |-> reg_rdata == $past(sh_div))
      else $error("divider readback wrong");
   a_ctrl_rsvd: assert property (
      $past(reg_addr) == `APBO_ADDR_CLOCK_CTRL |-> reg_rdata[7:4] == 4'h0)
      else $error("control reserved bits not zero");
endmodule : apbo_port_clock_asserts
bind apbo_port_clock apbo_port_clock_asserts apbo_port_clock_asserts_inst (.*);

// ==== sim/apbo_host_model.sv ====
`timescale 1ns/1ps
// Audio host: supplies word clock and bit clock for one frame at a time
module apbo_host_model (
   input wire logic ref_clk,
   input wire logic frame,
   output logic ext_bitclk,
   output logic wordclk_in
);
   logic [11:0] cnt; // Cycles since frame start, wide enough for offset 255
   // Counter rests at zero between frames; frame low holds both clocks low
   always_ff @(posedge ref_clk) begin
      cnt <= frame ? cnt + 12'h001 : 12'h000;
   end
   assign ext_bitclk = frame && cnt[2];
   // Word clock rises while the bit clock is low, avoiding an ambiguous edge
   assign wordclk_in = frame && cnt < 12'h008;
endmodule : apbo_host_model

// ==== sim/tb_apbo_port_clock.sv ====
`timescale 1ns/1ps
module tb_apbo_port_clock;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1; // Dropped once to check the freeze
   logic reg_wr = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic conv_clk_tick = 1'b1; // Converter ticks every cycle
   logic modulator_clock_tick = 1'b0; // Modulator ticks every other cycle
   logic [1:0] iface_format = 2'h0;
   logic bitclk_dir_out = 1'b1;
   logic core_powered = 1'b1;
   logic frame = 1'b0;
   logic word_valid = 1'b0;
   logic [7:0] word_data = 8'h00;
   logic ext_bitclk, wordclk_in, bitclk_out, bitclk_oe_n, bitclk_sec_out;
   logic clocks_active, slot_start, word_ready, serial_out, ok;
   int n_mismatch = 0;
   int comparisons = 0;
   int cyc = 0;
   apbo_port_clock #(
      .WORD_W(8)
   ) apbo_port_clock_inst (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .reg_wr(reg_wr),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .conv_clk_tick(conv_clk_tick),
      .modulator_clock_tick(modulator_clock_tick),
      .iface_format(iface_format),
      .bitclk_dir_out(bitclk_dir_out),
      .core_powered(core_powered),
      .ext_bitclk(ext_bitclk),
      .wordclk_in(wordclk_in),
      .bitclk_out(bitclk_out),
      .bitclk_oe_n(bitclk_oe_n),
      .bitclk_sec_out(bitclk_sec_out),
      .clocks_active(clocks_active),
      .slot_start(slot_start),
      .word_valid(word_valid),
      .word_ready(word_ready),
      .word_data(word_data),
      .serial_out(serial_out)
   );
   apbo_host_model apbo_host_model_inst (
      .ref_clk(ref_clk),
      .frame(frame),
      .ext_bitclk(ext_bitclk),
      .wordclk_in(wordclk_in)
   );
   always #5 ref_clk = ~ref_clk;
   // Tick source and hang guard
   always @(posedge ref_clk) begin
      modulator_clock_tick <= ~modulator_clock_tick;
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_mismatch++;
         summarize();
      end
   end
   task automatic chk(string w, logic [15:0] e, logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s exp %h got %h", w, e, g);
      end
   endtask : chk
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      repeat (2) @(posedge ref_clk);
      #1;
      chk("reg", {8'h0, e}, {8'h0, reg_rdata});
   endtask : rd
   // Cycles between second and third bit clock rise; zero if it stands still
   task automatic period(output int p);
      logic q;
      int k;
      p = 0;
      k = 0;
      q = bitclk_out;
      for (int t = 0; t < 700 && k < 3; t++) begin
         @(posedge ref_clk);
         #1;
         if (bitclk_out && !q) k++;
         if (k == 2) p++;
         q = bitclk_out;
      end
   endtask : period
   task automatic t_div(logic [7:0] c, logic [7:0] d, logic [15:0] e);
      int p;
      wr(8'h1d, c);
      wr(8'h1e, d);
      period(p);
      chk("period", e, p[15:0]);
   endtask : t_div
   task automatic t_invert();
      wr(8'h1e, 8'h04);
      wr(8'h1d, 8'h08);
      repeat (4) @(posedge ref_clk);
      #1;
      chk("inv", 16'h1, {15'h0, bitclk_out});
      wr(8'h1d, 8'h00);
      repeat (4) @(posedge ref_clk);
      #1;
      chk("inv", 16'h0, {15'h0, bitclk_out});
   endtask : t_invert
   // Clock enable low must hold the running bit clock where it stands
   task automatic t_freeze();
      logic q;
      int p;
      @(posedge ref_clk);
      clk_en <= 1'b0;
      @(posedge ref_clk);
      #1;
      q = bitclk_out;
      // Fourteen cycles is an odd number of half periods at ratio four
      repeat (14) @(posedge ref_clk);
      #1;
      chk("frozen", {15'h0, q}, {15'h0, bitclk_out});
      @(posedge ref_clk);
      clk_en <= 1'b1;
      period(p);
      chk("resume", 16'd4, p[15:0]);
   endtask : t_freeze
   // Count host bit clock rises from word clock rise to slot start, then gather the word
   task automatic t_slot(logic [7:0] off, logic [1:0] f, logic [15:0] e, logic [7:0] w);
      logic [15:0] n;
      logic [7:0] got;
      logic q;
      n = 16'h0;
      got = 8'h00;
      q = 1'b0;
      iface_format <= f;
      bitclk_dir_out <= 1'b0;
      wr(8'h1c, off);
      frame <= 1'b1;
      for (int t = 0; t < 2200 && !slot_start; t++) begin
         @(posedge ref_clk);
         #1;
         if (ext_bitclk && !q && !slot_start) n++;
         q = ext_bitclk;
      end
      if (!slot_start) n = 16'hffff;
      chk("slot", e, n);
      // Each later host bit clock rise shifts one bit out, MSB first
      for (int i = 0; i < 8 && n != 16'hffff; i++) begin
         for (int t = 0; t < 20 && !(ext_bitclk && !q); t++) begin
            q = ext_bitclk;
            @(posedge ref_clk);
            #1;
         end
         q = ext_bitclk;
         @(posedge ref_clk);
         #1;
         got = {got[6:0], serial_out};
      end
      // The frame runs until the slot is done, so the next word clock finds it idle
      if (n != 16'hffff) chk("word", {8'h00, w}, {8'h00, got});
      @(posedge ref_clk);
      frame <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask : t_slot
   task automatic push(logic [7:0] d);
      word_valid <= 1'b1;
      word_data <= d;
      #1;
      ok = word_ready;
      @(posedge ref_clk);
      word_valid <= 1'b0;
      @(posedge ref_clk);
   endtask : push
   // Fill two words with no slot to drain them, then drain by frames
   task automatic t_buf();
      iface_format <= 2'h0;
      push(8'h80);
      push(8'h7f);
      push(8'hff);
      chk("full", 16'h0, {15'h0, ok});
      t_slot(8'h03, 2'h1, 16'h3, 8'h80);
      t_slot(8'h03, 2'h1, 16'h3, 8'h7f);
      // The refused third word must not appear; an empty buffer sends zeros
      t_slot(8'h03, 2'h1, 16'h3, 8'h00);
      #1;
      chk("drained", 16'h1, {15'h0, word_ready});
   endtask : t_buf
   task automatic summarize();
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rd(8'h1c, 8'h00);
      rd(8'h1e, 8'h01);
      wr(8'h1d, 8'hff);
      rd(8'h1d, 8'h0f);
      wr(8'h1c, 8'hff);
      rd(8'h1c, 8'hff);
      t_div(8'h00, 8'h84, 16'd4);
      t_div(8'h00, 8'h80, 16'd128);
      t_div(8'h00, 8'hff, 16'd127);
      t_div(8'h01, 8'h83, 16'd6);
      t_div(8'h02, 8'h84, 16'd0);
      t_div(8'h00, 8'h04, 16'd0);
      core_powered <= 1'b0;
      t_div(8'h00, 8'h84, 16'd0);
      t_div(8'h04, 8'h84, 16'd4);
      core_powered <= 1'b1;
      t_invert();
      wr(8'h1e, 8'h84);
      t_freeze();
      t_slot(8'h00, 2'h1, 16'h0, 8'h00);
      t_slot(8'h05, 2'h1, 16'h5, 8'h00);
      t_slot(8'hff, 2'h1, 16'd255, 8'h00);
      t_slot(8'h02, 2'h0, 16'hffff, 8'h00);
      t_buf();
      summarize();
   end
endmodule : tb_apbo_port_clock
